/* pkg/vpl_map.vh */
`ifndef VPL_MAP_VH
`define VPL_MAP_VH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define VPL_IDX_RES_CFG 10'h0a4
`define VPL_IDX_SYNC_CFG 10'h0a5
`define VPL_IDX_LOCK_HI 10'h0a6
`define VPL_IDX_LOCK_LO 10'h0a7
`define VPL_IDX_FREQ_CODE 10'h0a3
`define VPL_IDX_STATUS 10'h0a8
`define VPL_IDX_W 10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VPL_RES_HI 7
`define VPL_RES_LO 6
`define VPL_SYNC_EN_BIT 7
`define VPL_LO_CNT_HI 7
`define VPL_LO_CNT_LO 3
`define VPL_FRES_BIT 2
`define VPL_HYST_HI 1
`define VPL_HYST_LO 0
`define VPL_FREQ_HI 4
`define VPL_FREQ_LO 0
`define VPL_STAT_LOCK_BIT 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VPL_RST_BYTE 8'h00
`define VPL_RST_FREQ 5'h00

// ----------------------------------------
// Encodings and timing counts
// ----------------------------------------
`define VPL_RES_5MHZ 2'b00
`define VPL_RES_10MHZ 2'b01
`define VPL_RES_20MHZ 2'b10
`define VPL_RES_40MHZ 2'b11
`define VPL_REF_DIV_5MHZ 3'h7
`define VPL_REF_DIV_10MHZ 3'h3
`define VPL_REF_DIV_20MHZ 3'h1
`define VPL_REF_DIV_40MHZ 3'h0
`define VPL_K_5MHZ 8'h19
`define VPL_K_10MHZ 8'h31
`define VPL_K_20MHZ 8'h61
`define VPL_K_40MHZ 8'hc3
`define VPL_HYST_OFF 2'b00
`define VPL_HYST_11B 2'b01
`define VPL_HYST_8B 2'b10
`define VPL_LOCK_TOL 13'h0001
`define VPL_CNT_MAX 13'h1fff

`endif

/* verilog/vpl_hyst.v */
`include "vpl_map.vh"

// PWM input hysteresis filter: small input moves are held off.
module vpl_hyst (
  // Clock, reset and enable.
  input wire clock,
  input wire rst,
  input wire ce,
  // Mode and data.
  input wire [1:0] mode,
  input wire [10:0] level_in,
  output reg [10:0] level_q
);

  wire [11:0] in_w;
  wire [11:0] cur_w;
  wire [8:0] in8_w;
  wire [8:0] cur8_w;
  reg take_d;

  assign in_w = {1'b0, level_in};
  assign cur_w = {1'b0, level_q};
  assign in8_w = {1'b0, level_in[10:3]};
  assign cur8_w = {1'b0, level_q[10:3]};

  // ----------------------------------------
  // Update decision
  // ----------------------------------------
  // A change of one step at the chosen resolution is ignored so the output cannot toggle.
  always @*
  begin
    case (mode)
      `VPL_HYST_11B:
        take_d = (in_w > cur_w + 12'h001) || (in_w + 12'h001 < cur_w); // [RL4]
      `VPL_HYST_8B:
        take_d = (in8_w > cur8_w + 9'h001) || (in8_w + 9'h001 < cur8_w); // [RL4]
      default:
        take_d = 1'b1; // Off, and the unused code acts as off.
    endcase
  end

  // Filtered level register.
  always @(posedge clock)
  begin
    if (rst)
      level_q <= 11'h000;
    else if (ce && take_d)
      level_q <= level_in;
  end

endmodule // vpl_hyst

/* verilog/vpl_cfg.v */
// Operation
// [RL1] Bits 7:3 of the low lock-count byte hold bits 4:0 of the 13-bit lock count.
// [RL2] The 13-bit lock count is used only while sync locking is on, and ignored otherwise.
// [RL3] Select bit 0 takes the PWM frequency from the code field, 1 from the external resistor.
// [RL4] The hysteresis field ignores one-step input changes: 00 off, 01 at 11 bits, 10 at 8 bits.
// [RL5] The resolution field picks a 5/10/20/40 MHz PLL, with lock factors 26/50/98/196.
// [RL6] With the sync enable set the PLL follows the sync input, otherwise that input is ignored.
`include "vpl_map.vh"

module vpl_cfg (
  // Clock, reset and enable.
  input wire clock,
  input wire rst,
  input wire ce,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Display sync pin.
  input wire vsync_in,
  // PWM input level from the decoder.
  input wire [10:0] pwm_in_level,
  // Controls and status to the rest of the driver.
  output wire sync_enabled,
  output wire freq_from_resistor,
  output wire [4:0] pwm_output_freq_code,
  output wire [1:0] pll_freq_sel,
  output reg pll_tick,
  output reg sync_locked,
  output reg [12:0] sync_period_count,
  output wire [10:0] pwm_level_out
);

  // ----------------------------------------
  // Stored configuration
  // ----------------------------------------
  reg [7:0] res_cfg_q;
  reg [7:0] sync_cfg_q;
  reg [7:0] lock_hi_q;
  reg [7:0] lock_lo_q;
  reg [4:0] freq_code_q;
  reg ans_q;
  reg vs_meta_q;
  reg vs_sync_q;
  reg vs_prev_q;
  reg [2:0] ref_div_q;
  reg [7:0] unit_div_q;
  reg [12:0] unit_cnt_q;
  wire [12:0] lock_count;
  wire sync_on;
  wire vs_edge;
  wire unit_tick;
  wire [`VPL_IDX_W-1:0] idx;
  wire addr_ok;
  wire setup;
  reg [2:0] ref_top;
  reg [7:0] k_top;
  reg [31:0] rd_d;
  reg hit_d;

  assign lock_count = {lock_hi_q, lock_lo_q[`VPL_LO_CNT_HI:`VPL_LO_CNT_LO]}; // [RL1]
  assign sync_on = sync_cfg_q[`VPL_SYNC_EN_BIT];
  assign sync_enabled = sync_on; // [RL6]
  assign freq_from_resistor = lock_lo_q[`VPL_FRES_BIT]; // [RL3]
  assign pwm_output_freq_code = freq_code_q; // [RL3]
  assign pll_freq_sel = res_cfg_q[`VPL_RES_HI:`VPL_RES_LO]; // [RL5]

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign idx = paddr[`VPL_IDX_W+1:2];
  assign addr_ok = (paddr[31:`VPL_IDX_W+2] == 20'h00000) && (paddr[1:0] == 2'b00);
  // Staging happens at the first enabled edge that sees psel, not only at a clean setup
  // edge, so a setup cycle lost to a low enable still completes instead of hanging.
  assign setup = psel && !ans_q;
  // Pready is held low while the enable is low, so a frozen write never looks complete.
  assign pready = psel && penable && ans_q && ce;

  // Read mux and address hit; bits above the register width read as zero.
  always @*
  begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (idx)
      `VPL_IDX_RES_CFG:
        rd_d[7:0] = res_cfg_q;
      `VPL_IDX_SYNC_CFG:
        rd_d[7:0] = sync_cfg_q;
      `VPL_IDX_LOCK_HI:
        rd_d[7:0] = lock_hi_q;
      `VPL_IDX_LOCK_LO:
        rd_d[7:0] = lock_lo_q;
      `VPL_IDX_FREQ_CODE:
        rd_d[4:0] = freq_code_q;
      `VPL_IDX_STATUS:
      begin
        rd_d[12:0] = sync_period_count;
        rd_d[`VPL_STAT_LOCK_BIT] = sync_locked;
      end
      default:
        hit_d = 1'b0;
    endcase
    if (!addr_ok)
      hit_d = 1'b0;
    if (!hit_d)
      rd_d = 32'h00000000;
  end

  // Answer staging: read data and error are latched at the setup edge.
  always @(posedge clock)
  begin
    if (rst)
    begin
      ans_q <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (setup)
      begin
        ans_q <= 1'b1;
        prdata <= rd_d;
        pslverr <= !hit_d || (pwrite && idx == `VPL_IDX_STATUS);
      end
      else if (pready)
        ans_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Writes land at the completing edge only; errored writes change nothing.
  always @(posedge clock)
  begin
    if (rst)
    begin
      res_cfg_q <= `VPL_RST_BYTE;
      sync_cfg_q <= `VPL_RST_BYTE;
      lock_hi_q <= `VPL_RST_BYTE;
      lock_lo_q <= `VPL_RST_BYTE;
      freq_code_q <= `VPL_RST_FREQ;
    end
    else if (ce && pready && pwrite && !pslverr)
    begin
      case (idx)
        `VPL_IDX_RES_CFG:
          res_cfg_q <= pwdata[7:0];
        `VPL_IDX_SYNC_CFG:
          sync_cfg_q <= pwdata[7:0];
        `VPL_IDX_LOCK_HI:
          lock_hi_q <= pwdata[7:0];
        `VPL_IDX_LOCK_LO:
          lock_lo_q <= pwdata[7:0]; // [RL1]
        `VPL_IDX_FREQ_CODE:
          freq_code_q <= pwdata[`VPL_FREQ_HI:`VPL_FREQ_LO];
        default:
          freq_code_q <= freq_code_q;
      endcase
    end
  end

  // ----------------------------------------
  // Sync pin capture
  // ----------------------------------------
  // Two flops before any logic, then an edge detector on the clean copy.
  always @(posedge clock)
  begin
    if (rst)
    begin
      vs_meta_q <= 1'b0;
      vs_sync_q <= 1'b0;
      vs_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      vs_meta_q <= vsync_in;
      vs_sync_q <= vs_meta_q;
      vs_prev_q <= vs_sync_q;
    end
  end

  // A disabled sync input produces no edges at all.
  assign vs_edge = sync_on && vs_sync_q && !vs_prev_q; // [RL6]

  // ----------------------------------------
  // PLL rate and lock factor
  // ----------------------------------------
  // The 40 MHz reference is divided down to the selected PLL rate.
  always @*
  begin
    case (pll_freq_sel)
      `VPL_RES_5MHZ:
      begin
        ref_top = `VPL_REF_DIV_5MHZ;
        k_top = `VPL_K_5MHZ; // [RL5]
      end
      `VPL_RES_10MHZ:
      begin
        ref_top = `VPL_REF_DIV_10MHZ;
        k_top = `VPL_K_10MHZ; // [RL5]
      end
      `VPL_RES_20MHZ:
      begin
        ref_top = `VPL_REF_DIV_20MHZ;
        k_top = `VPL_K_20MHZ; // [RL5]
      end
      default:
      begin
        ref_top = `VPL_REF_DIV_40MHZ;
        k_top = `VPL_K_40MHZ; // [RL5]
      end
    endcase
  end

  assign unit_tick = pll_tick && (unit_div_q == k_top);

  // PLL tick and the divide-by-factor prescaler; a count left above the new factor by a resolution change is cleared to zero.
  always @(posedge clock)
  begin
    if (rst)
    begin
      ref_div_q <= 3'h0;
      pll_tick <= 1'b0;
      unit_div_q <= 8'h00;
    end
    else if (ce)
    begin
      pll_tick <= (ref_div_q >= ref_top);
      ref_div_q <= (ref_div_q >= ref_top) ? 3'h0 : ref_div_q + 3'h1;
      if (vs_edge || unit_tick || unit_div_q > k_top)
        unit_div_q <= 8'h00;
      else if (pll_tick)
        unit_div_q <= unit_div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Lock measurement
  // ----------------------------------------
  // Units between sync edges are compared with the programmed count; the count is only
  // consulted while locking is on, so stale values cannot claim lock.
  always @(posedge clock)
  begin
    if (rst)
    begin
      unit_cnt_q <= 13'h0000;
      sync_period_count <= 13'h0000;
      sync_locked <= 1'b0;
    end
    else if (ce)
    begin
      if (!sync_on)
      begin
        unit_cnt_q <= 13'h0000;
        sync_locked <= 1'b0; // [RL2]
      end
      else if (vs_edge)
      begin
        unit_cnt_q <= 13'h0000;
        sync_period_count <= unit_cnt_q;
        sync_locked <= (unit_cnt_q + `VPL_LOCK_TOL >= lock_count) &&
          (unit_cnt_q <= lock_count + `VPL_LOCK_TOL); // [RL2]
      end
      else if (unit_tick && unit_cnt_q != `VPL_CNT_MAX)
        unit_cnt_q <= unit_cnt_q + 13'h0001;
    end
  end

  // ----------------------------------------
  // PWM input hysteresis
  // ----------------------------------------
  vpl_hyst u_hyst (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .mode(lock_lo_q[`VPL_HYST_HI:`VPL_HYST_LO]), // [RL4]
    .level_in(pwm_in_level),
    .level_q(pwm_level_out)
  );

endmodule // vpl_cfg

/* sim/vpl_cfg_sva.sv */
module vpl_cfg_sva (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Controls and status.
  input wire sync_enabled,
  input wire freq_from_resistor,
  input wire [1:0] pll_freq_sel,
  input wire pll_tick,
  input wire sync_locked,
  input wire [12:0] sync_period_count,
  input wire [10:0] pwm_in_level,
  input wire [10:0] pwm_level_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadow of the hysteresis field
  // ----------------------------------------
  // The mode is not a port, so it is followed from completed writes.
  reg [1:0] hyst_q;
  wire wr_lo = psel && penable && pready && pwrite && !pslverr && paddr == 32'h29c;
  always @(posedge clock)
  begin
    if (rst)
      hyst_q <= 2'b00;
    else if (wr_lo)
      hyst_q <= pwdata[1:0];
  end
  fres_map_a: assert property (wr_lo |=> freq_from_resistor == $past(pwdata[2]))
    else $error("resistor select wrong");
  ready_wait_a: assert property (psel && !penable |=> pready) else $error("no ready");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("no error");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error data");
  lock_off_a: assert property (!sync_enabled |=> !sync_locked)
    else $error("locked while off");
  count_hold_a: assert property (!sync_enabled && !$past(sync_enabled) |=>
    $stable(sync_period_count)) else $error("count moved");
  tick_rate_a: assert property (pll_tick && pll_freq_sel == 2'b00 |=>
    (!pll_tick || pll_freq_sel != 2'b00) [*7]) else $error("tick early");
  hyst_pass_a: assert property (hyst_q == 2'b00 && !wr_lo |=>
    pwm_level_out == $past(pwm_in_level)) else $error("no pass");
  cover property (sync_locked);
  cover property (pready && pslverr);
  cover property (wr_lo);
endmodule // vpl_cfg_sva

bind vpl_cfg vpl_cfg_sva chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .sync_enabled(sync_enabled), .freq_from_resistor(freq_from_resistor),
  .pll_freq_sel(pll_freq_sel), .pll_tick(pll_tick), .sync_locked(sync_locked),
  .sync_period_count(sync_period_count), .pwm_in_level(pwm_in_level),
  .pwm_level_out(pwm_level_out));

/* sim/vpl_sync_src.sv */
// Display timing source: a short sync pulse every period cycles, low between pulses.
module vpl_sync_src (
  // Clock.
  input wire clock,
  // Control.
  input wire run,
  input wire [15:0] period,
  // Sync pin.
  output logic vsync_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial vsync_out = 1'b0;
  // The period sets the sync rate that the lock count is matched to.
  always @(posedge clock)
  begin
    cnt <= (!run || cnt + 1 >= period) ? 0 : cnt + 1;
    vsync_out <= run && cnt < 4;
  end
endmodule // vpl_sync_src

/* sim/vpl_cfg_tb_top.sv */
`include "vpl_map.vh"
module vpl_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_RES = `VPL_IDX_RES_CFG * 4;
  localparam logic [31:0] A_SYNC = `VPL_IDX_SYNC_CFG * 4;
  localparam logic [31:0] A_HI = `VPL_IDX_LOCK_HI * 4;
  localparam logic [31:0] A_LO = `VPL_IDX_LOCK_LO * 4;
  localparam logic [31:0] A_STAT = `VPL_IDX_STATUS * 4;
  localparam logic [31:0] A_FREQ = `VPL_IDX_FREQ_CODE * 4;
  localparam int PER = 3920;
  logic clock, rst, ce, psel, penable, pwrite, pready, pslverr, vsync, sync_run, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [10:0] pwm_in_level, pwm_level_out;
  logic sync_enabled, freq_from_resistor, pll_tick, sync_locked;
  logic [4:0] pwm_output_freq_code;
  logic [1:0] pll_freq_sel;
  logic [12:0] sync_period_count;
  int errors = 0;
  int n_checks = 0;
  // Hysteresis table: mode, input step and filtered level.
  logic [1:0] hm [5] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b00};
  logic [10:0] hi [5] = '{11'h401, 11'h402, 11'h408, 11'h410, 11'h401};
  logic [10:0] he [5] = '{11'h400, 11'h402, 11'h402, 11'h410, 11'h401};
  vpl_cfg dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .vsync_in(vsync), .pwm_in_level(pwm_in_level),
    .sync_enabled(sync_enabled), .freq_from_resistor(freq_from_resistor),
    .pwm_output_freq_code(pwm_output_freq_code), .pll_freq_sel(pll_freq_sel),
    .pll_tick(pll_tick), .sync_locked(sync_locked),
    .sync_period_count(sync_period_count), .pwm_level_out(pwm_level_out));
  vpl_sync_src src (.clock(clock), .run(sync_run), .period(16'(PER)), .vsync_out(vsync));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  // One transfer, then an idle cycle so no signal is driven twice in one step.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // No cycle count is assumed here; only the watchdog ends a wait that never completes.
    while (pready !== 1'b1)
      @(posedge clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // A hang costs a mismatch and ends the run the normal way.
  initial
  begin
    #2000000;
    errors++;
    results;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {rst, ce, psel, penable, pwrite, sync_run} = 6'b110000;
    paddr = 32'h0;
    pwdata = 32'h0;
    pwm_in_level = 11'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    xfer(0, A_LO, 0);
    chk(rdat, 32'h0);
    xfer(1, A_LO, 32'hfd);
    xfer(0, A_LO, 0);
    chk(rdat, 32'hfd);
    chk(32'(freq_from_resistor), 1);
    xfer(1, A_LO, 32'h0);
    chk(32'(freq_from_resistor), 0);
    // The code field keeps only its five bits, and the status word refuses writes.
    xfer(1, A_FREQ, 32'hf5);
    chk(32'(pwm_output_freq_code), 32'h15);
    xfer(0, A_FREQ, 0);
    chk(rdat, 32'h15);
    xfer(1, A_STAT, 32'h1);
    chk(32'(rerr), 1);
    xfer(0, A_LO + 1, 0);
    chk(32'(rerr), 1);
    chk(rdat, 0);
    xfer(0, 32'h400, 0);
    chk(32'(rerr), 1);
    pwm_in_level <= 11'h400;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1, A_LO, 32'(hm[i]));
      pwm_in_level <= hi[i];
      repeat (3) @(posedge clock);
      chk(32'(pwm_level_out), 32'(he[i]));
    end
    // At 40 MHz one unit is 196 cycles, so the sync period is 20 units.
    xfer(1, A_RES, 32'hc0);
    chk(32'(pll_freq_sel), 3);
    xfer(1, A_HI, 0);
    xfer(1, A_LO, 32'ha0);
    xfer(1, A_SYNC, 32'h80);
    chk(32'(sync_enabled), 1);
    sync_run <= 1'b1;
    repeat (3 * PER) @(posedge clock);
    chk(32'(sync_locked), 1);
    chk(32'(sync_period_count >= 19 && sync_period_count <= 21), 1);
    xfer(0, A_STAT, 0);
    chk(32'(rdat[16]), 1);
    xfer(1, A_LO, 32'hf8);
    repeat (2 * PER) @(posedge clock);
    chk(32'(sync_locked), 0);
    // Lock again, then at the 10 and 20 MHz rates (200 and 196 cycles a unit); the
    // extra cycles make sure a full period at the new rate has been measured.
    xfer(1, A_LO, 32'ha0);
    repeat (2 * PER) @(posedge clock);
    chk(32'(sync_locked), 1);
    for (int r = 1; r < 3; r++)
    begin
      xfer(1, A_RES, 32'(r * 64));
      chk(32'(pll_freq_sel), 32'(r));
      repeat (2 * PER + 8) @(posedge clock);
      chk(32'(sync_locked), 1);
      chk(32'(sync_period_count >= 19 && sync_period_count <= 21), 1);
    end
    // The lock held above must now be dropped, and later sync edges ignored.
    xfer(1, A_SYNC, 0);
    chk(32'(sync_enabled), 0);
    repeat (2 * PER) @(posedge clock);
    chk(32'(sync_locked), 0);
    results;
  end
endmodule // vpl_cfg_tb_top
